// *** isf_bus_model.sv ***
// isf_bus_model: far-side bus events chosen by an op code.
// assumes op_in is held for one clock per event.
`timescale 1ns/1ns
module isf_bus_model
    import isf_pkg::*;
(
    input  wire logic [2:0]      op_in,
    input  wire logic            rnd_in,
    output isf_pkg::isf_bus_ev_t bus_out
);
    logic drv;
    assign drv = rnd_in | (op_in == 3'h5);
    // op 4 lets another master pull the line against us
    assign bus_out = '{master: 1'h1, transmit: 1'h1, scl_rise: op_in == 3'h4 || op_in == 3'h7,
        sda_internal: drv, sda_pin: drv ^ (op_in == 3'h4), start_det: op_in == 3'h5,
        stop_det: op_in == 3'h3, frame_done: op_in == 3'h2, ack_slot: op_in == 3'h1,
        ack_seen: 1'h0, last_bit_rx: op_in == 3'h6};
endmodule

// *** isf_chk_asserts.sv ***
// isf_chk: port assertions for the status flag block.
// assumes it is bound onto isf_status_flags; one clock domain.
`timescale 1ns/1ns
module isf_chk
    import isf_pkg::*;
(
    input  wire logic           core_clk_in,
    input  wire logic           rst_in,
    input  isf_pkg::isf_fmt_t    fmt_in,
    input  wire logic           ack_check_enable_in,
    input  isf_pkg::isf_bus_ev_t bus_in,
    input  isf_pkg::isf_sw_t     sw_in,
    input  wire logic           rx_xfer_in,
    input  wire logic [7:0]     rx_shift_reg_in,
    input  wire logic           rx_data_read_in,
    input  wire logic [7:0]     status_out,
    input  wire logic [7:0]     rx_data_reg_out,
    input  wire logic           rx_full_flag_out
);
    isf_bus_ev_t b;
    logic [7:0]  s;
    assign b = bus_in;
    assign s = status_out;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    property p_nk; b.transmit && b.ack_slot && !b.ack_seen && ack_check_enable_in |=> s[4];
    endproperty
    a_nk: assert property (p_nk) else $error("no-ack not set");
    property p_st; b.stop_det && b.frame_done |=> s[3]; endproperty
    a_st: assert property (p_st) else $error("stop not set");
    property p_sr; $rose(s[3]) |-> $past(b.stop_det); endproperty
    a_sr: assert property (p_sr) else $error("stop rose alone");
    property p_sf; $fell(s[3]) |-> $past(sw_in.wr) && !$past(sw_in.wdata[3]); endproperty
    a_sf: assert property (p_sf) else $error("stop fell alone");
    property p_nf; $fell(s[4]) |-> $past(sw_in.wr) && !$past(sw_in.wdata[4]); endproperty
    a_nf: assert property (p_nf) else $error("no-ack fell alone");
    property p_af; $rose(s[2]) |-> $past(b.scl_rise || b.start_det || b.last_bit_rx);
    endproperty
    a_af: assert property (p_af) else $error("arb/overrun rose alone");
    property p_ar; fmt_in == ISF_FMT_BUS && b.master && b.transmit && b.scl_rise
        && b.sda_internal != b.sda_pin |=> s[2]; endproperty
    a_ar: assert property (p_ar) else $error("arb not set");
    property p_as; fmt_in == ISF_FMT_BUS && b.master && b.sda_internal && b.start_det |=> s[2];
    endproperty
    a_as: assert property (p_as) else $error("start arb not set");
    property p_ov; fmt_in == ISF_FMT_SYNC && b.last_bit_rx && rx_full_flag_out |=> s[2];
    endproperty
    a_ov: assert property (p_ov) else $error("overrun not set");
    property p_rx; rx_xfer_in && !b.last_bit_rx
        |=> rx_full_flag_out && rx_data_reg_out == $past(rx_shift_reg_in); endproperty
    a_rx: assert property (p_rx) else $error("rx load wrong");
endmodule
bind isf_status_flags isf_chk isf_chk_inst (.*);

// *** isf_pkg.sv ***
// isf_pkg: constants and carrier types for the i2c status flag block.
// assumes a single 10 MHz system clock domain.
package isf_pkg;
    // ****************************************************************
    // status register layout
    // ****************************************************************
    localparam int unsigned STAT_W        = 8;
    localparam int unsigned BIT_NO_ACK    = 4;
    localparam int unsigned BIT_STOP      = 3;
    localparam int unsigned BIT_ARB_OVR   = 2;
    localparam logic        FLAG_RESET    = 1'h0;
    localparam int unsigned WORD_W        = 8;

    // ****************************************************************
    // carrier types
    // ****************************************************************
    typedef enum logic [0:0] {
        ISF_FMT_BUS  = 1'h0,
        ISF_FMT_SYNC = 1'h1
    } isf_fmt_t;

    // bus-side observations, one cycle pulses except levels noted
    typedef struct packed {
        logic master;        // level: master mode
        logic transmit;      // level: transmit mode
        logic scl_rise;      // pulse
        logic sda_internal;  // level: what we drive
        logic sda_pin;       // level: sampled line
        logic start_det;     // pulse
        logic stop_det;      // pulse
        logic frame_done;    // pulse: a frame finished
        logic ack_slot;      // pulse: ack bit sampled in transmit
        logic ack_seen;      // level at ack_slot: 1 = acknowledged
        logic last_bit_rx;   // pulse: final bit of a word received
    } isf_bus_ev_t;

    // software access to the status register
    typedef struct packed {
        logic               rd;
        logic               wr;
        logic [STAT_W-1:0]  wdata;
    } isf_sw_t;
endpackage

// *** isf_status_flags.sv ***
// isf_status_flags: no-ack, stop-detected and arb-lost/overrun flags.
// assumes bus events are pre-decoded and synchronous to core_clk_in.
//
// Contract
// RQ1: no-ack flag clears only by writing 0 after reading it as 1.
// RQ2: no-ack flag sets on missing ack in transmit when ack check enabled.
// RQ3: stop flag sets when stop condition follows a frame transfer.
// RQ4: stop flag clears only by writing 0 after reading it as 1.
// RQ5: stop flag at bit 3, resets 0, readable and writable.
// RQ6: arb/overrun flag at bit 2, resets 0; arb in bus, overrun in sync.
// RQ7: master transmit: internal data differs from pin at clock rise sets arb lost.
// RQ8: master driving data high while start detected sets arb lost.
// RQ9: sync format: final bit received with rx full set sets overrun.
// RQ10: data differing from sent data during contention sets flag to 1.
// RQ11: rx full sets when received word moves into receive data register.
// RQ12: writing 1 leaves flags unchanged; only hardware sets them.
`timescale 1ns/1ns
module isf_status_flags
    import isf_pkg::*;
(
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_in,
    input  isf_pkg::isf_fmt_t          fmt_in,
    input  wire logic                  ack_check_enable_in,
    input  isf_pkg::isf_bus_ev_t       bus_in,
    input  isf_pkg::isf_sw_t           sw_in,
    input  wire logic                  rx_xfer_in,
    input  wire logic [isf_pkg::WORD_W-1:0] rx_shift_reg_in,
    input  wire logic                  rx_data_read_in,
    output logic [isf_pkg::STAT_W-1:0] status_out,
    output logic [isf_pkg::WORD_W-1:0] rx_data_reg_out,
    output logic                       rx_full_flag_out
);
    import isf_pkg::*;

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // a flag placed outside the status word would silently vanish
    if (BIT_NO_ACK >= STAT_W || BIT_STOP >= STAT_W || BIT_ARB_OVR >= STAT_W) begin : g_bad_layout
        $error("status flag bit outside the status word");
    end

    // ****************************************************************
    // state
    // ****************************************************************
    logic              no_ack_flag_q;
    logic              no_ack_flag_d;
    logic              stop_flag_q;
    logic              stop_flag_d;
    logic              arb_lost_overrun_flag_q;
    logic              arb_lost_overrun_flag_d;
    logic              rx_full_flag_q;
    logic              rx_full_flag_d;
    logic [WORD_W-1:0] rx_data_q;
    logic [WORD_W-1:0] rx_data_d;
    // read-as-1 arms: clearing needs a prior read that saw the flag set
    logic              no_ack_arm_q;
    logic              no_ack_arm_d;
    logic              stop_arm_q;
    logic              stop_arm_d;
    logic              arb_arm_q;
    logic              arb_arm_d;
    // remembers a finished frame so a bare stop does not set the flag
    logic              frame_seen_q;
    logic              frame_seen_d;

    // ****************************************************************
    // set events
    // ****************************************************************
    logic              fmt_bus;
    logic              fmt_sync;
    logic              ack_missing;
    logic              arb_mismatch;
    logic              arb_start_high;
    logic              set_no_ack;
    logic              set_stop;
    logic              set_arb;
    logic              set_ovr;

    // set wins over clear; a write of 1 is ignored
    function automatic logic flag_next(input logic cur,
                                       input logic set,
                                       input logic arm,
                                       input logic wr,
                                       input logic wbit);
        flag_next = set ? 1'h1 : ((wr && !wbit && arm) ? 1'h0 : cur);
    endfunction

    // arm tracks a read that returned 1; a write consumes it
    function automatic logic arm_next(input logic arm,
                                      input logic cur,
                                      input logic rd,
                                      input logic wr);
        arm_next = wr ? 1'h0 : ((rd && cur) ? 1'h1 : arm);
    endfunction

    always_comb begin
        fmt_bus = (fmt_in == ISF_FMT_BUS);
        fmt_sync = (fmt_in == ISF_FMT_SYNC);
        ack_missing = bus_in.ack_slot && !bus_in.ack_seen;
        arb_mismatch = bus_in.transmit && bus_in.scl_rise
                       && (bus_in.sda_internal != bus_in.sda_pin);         // RQ7 RQ10
        arb_start_high = bus_in.sda_internal && bus_in.start_det;          // RQ8
        set_no_ack = bus_in.transmit && ack_missing && ack_check_enable_in; // RQ2
        set_stop = bus_in.stop_det && (frame_seen_q || bus_in.frame_done); // RQ3
        set_arb = fmt_bus && bus_in.master && (arb_mismatch || arb_start_high);
        set_ovr = fmt_sync && bus_in.last_bit_rx && rx_full_flag_q;       // RQ9
    end

    // ****************************************************************
    // no-ack flag
    // ****************************************************************
    always_comb begin
        no_ack_flag_d = flag_next(no_ack_flag_q, set_no_ack, no_ack_arm_q,
                                  sw_in.wr, sw_in.wdata[BIT_NO_ACK]);      // RQ1 RQ12
        no_ack_arm_d = arm_next(no_ack_arm_q, no_ack_flag_q, sw_in.rd, sw_in.wr);
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            no_ack_flag_q <= FLAG_RESET;
            no_ack_arm_q <= FLAG_RESET;
        end else begin
            no_ack_flag_q <= no_ack_flag_d;
            no_ack_arm_q <= no_ack_arm_d;
        end
    end

    // ****************************************************************
    // stop-detected flag
    // ****************************************************************
    always_comb begin
        frame_seen_d = bus_in.stop_det ? 1'h0
                     : (bus_in.frame_done ? 1'h1 : frame_seen_q);
        stop_flag_d = flag_next(stop_flag_q, set_stop, stop_arm_q,
                                sw_in.wr, sw_in.wdata[BIT_STOP]);          // RQ4 RQ5 RQ12
        stop_arm_d = arm_next(stop_arm_q, stop_flag_q, sw_in.rd, sw_in.wr);
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            stop_flag_q <= FLAG_RESET;
            stop_arm_q <= FLAG_RESET;
            frame_seen_q <= FLAG_RESET;
        end else begin
            stop_flag_q <= stop_flag_d;
            stop_arm_q <= stop_arm_d;
            frame_seen_q <= frame_seen_d;
        end
    end

    // ****************************************************************
    // arbitration-lost / overrun flag
    // ****************************************************************
    // one bit serves both formats; the format decides which event counts
    always_comb begin
        arb_lost_overrun_flag_d = flag_next(arb_lost_overrun_flag_q,
                                            set_arb || set_ovr, arb_arm_q,
                                            sw_in.wr,
                                            sw_in.wdata[BIT_ARB_OVR]);     // RQ6 RQ12
        arb_arm_d = arm_next(arb_arm_q, arb_lost_overrun_flag_q, sw_in.rd, sw_in.wr);
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            arb_lost_overrun_flag_q <= FLAG_RESET;
            arb_arm_q <= FLAG_RESET;
        end else begin
            arb_lost_overrun_flag_q <= arb_lost_overrun_flag_d;
            arb_arm_q <= arb_arm_d;
        end
    end

    // ****************************************************************
    // receive data register and full flag
    // ****************************************************************
    // overrun keeps the old word: the new one is dropped
    always_comb begin
        rx_data_d = rx_data_q;
        rx_full_flag_d = rx_full_flag_q;
        if (rx_data_read_in) begin
            rx_full_flag_d = 1'h0;
        end
        if (rx_xfer_in && !set_ovr) begin
            rx_data_d = rx_shift_reg_in;
            rx_full_flag_d = 1'h1;                                         // RQ11
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_full_flag_q <= FLAG_RESET;
            rx_data_q <= '0;
        end else begin
            rx_full_flag_q <= rx_full_flag_d;
            rx_data_q <= rx_data_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // unused status bits read as 0
    always_comb begin
        status_out = '0;
        status_out[BIT_NO_ACK] = no_ack_flag_q;
        status_out[BIT_STOP] = stop_flag_q;                                // RQ5
        status_out[BIT_ARB_OVR] = arb_lost_overrun_flag_q;                 // RQ6
    end

    assign rx_data_reg_out = rx_data_q;
    assign rx_full_flag_out = rx_full_flag_q;
endmodule

// *** isf_status_flags_tb.sv ***
// isf_status_flags_tb: directed flag checks with random line levels.
// assumes the bus model answers combinationally to its op code.
`timescale 1ns/1ns
module isf_status_flags_tb;
    import isf_pkg::*;
    logic core_clk_in = 1'h0, rst_in = 1'h1, ack_check_enable_in = 1'h1, rx_xfer_in = 1'h0;
    logic rx_data_read_in = 1'h0, rx_full_flag_out;
    logic [7:0] rx_shift_reg_in = 8'h2C, status_out, rx_data_reg_out;
    logic [2:0] op = 3'h0;
    logic [16:0] e, q[$];
    logic [7:0] word = 8'h00;
    logic drop = 1'h0;
    int bad_count = 0, checks_done = 0;
    isf_fmt_t fmt_in = ISF_FMT_BUS;
    isf_sw_t sw_in = '0;
    isf_bus_ev_t bus_in;
    isf_bus_model isf_bus_model_inst (.op_in(op), .rnd_in(rx_shift_reg_in[0]), .bus_out(bus_in));
    isf_status_flags isf_status_flags_inst (.*);
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        lfsr = {v[6:0], ^(v & 8'hB8)};
    endfunction
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic step(input logic [2:0] o, input logic [9:0] w, input logic [1:0] x,
                        input logic [8:0] ex);
        @(posedge core_clk_in);
        #1 {op, sw_in, rx_data_read_in, rx_xfer_in} = {o, w, x};
        rx_shift_reg_in = lfsr(rx_shift_reg_in);
        // the data register takes the word unless an overrun drops it
        if (x[0] && !drop) begin
            word = rx_shift_reg_in;
        end
        q.push_back({word, ex});
    endtask
    initial forever #50 core_clk_in = ~core_clk_in;
    initial begin
        #20000 bad_count++;
        report_and_stop();
    end
    initial forever begin
        @(posedge core_clk_in);
        if (q.size() > 0) begin
            e = q.pop_front();
            #2 check({rx_data_reg_out, rx_full_flag_out, status_out}, e);
        end
    end
    initial begin
        repeat (16) @(posedge core_clk_in);
        #1 rst_in = 1'h0;
        step(3'h2, 10'h0, 2'h0, 9'h0);
        step(3'h3, 10'h0, 2'h0, 9'h8);
        step(3'h0, 10'h100, 2'h0, 9'h8);
        step(3'h0, 10'h200, 2'h0, 9'h8);
        step(3'h0, 10'h1FF, 2'h0, 9'h8);
        step(3'h0, 10'h100, 2'h0, 9'h8);
        step(3'h0, 10'h200, 2'h0, 9'h8);
        step(3'h0, 10'h100, 2'h0, 9'h0);
        step(3'h3, 10'h0, 2'h0, 9'h0);
        $display("test stop end");
        step(3'h1, 10'h200, 2'h0, 9'h10);
        step(3'h0, 10'h100, 2'h0, 9'h10);
        step(3'h0, 10'h200, 2'h0, 9'h10);
        step(3'h0, 10'h100, 2'h0, 9'h0);
        ack_check_enable_in = 1'h0;
        step(3'h1, 10'h0, 2'h0, 9'h0);
        $display("test no-ack end");
        step(3'h4, 10'h200, 2'h0, 9'h4);
        step(3'h0, 10'h200, 2'h0, 9'h4);
        step(3'h7, 10'h100, 2'h0, 9'h0);
        step(3'h5, 10'h0, 2'h0, 9'h4);
        step(3'h0, 10'h200, 2'h0, 9'h4);
        $display("test arbitration end");
        fmt_in = ISF_FMT_SYNC;
        step(3'h6, 10'h100, 2'h1, 9'h100);
        drop = 1'h1;
        step(3'h6, 10'h0, 2'h1, 9'h104);
        step(3'h0, 10'h0, 2'h2, 9'h4);
        $display("test overrun end");
        repeat (3) @(posedge core_clk_in);
        report_and_stop();
    end
endmodule
